/* include/rd_seq_pkg.sv */
package rd_seq_pkg;

  // ----------------------------------------
  // Address space
  // ----------------------------------------
  localparam int ADDR_W = 16;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [15:0] ADDR_LAST = 16'hffff;

  // ----------------------------------------
  // Slave address byte
  // ----------------------------------------
  localparam logic [3:0] ID_ARRAY = 4'ha;
  localparam logic [3:0] ID_CTRL = 4'hd;
  localparam logic [2:0] DEV_SEL = 3'h7;
  localparam logic [3:0] BIT_LAST = 4'h8;

  // ----------------------------------------
  // Commands from the link side
  // ----------------------------------------
  localparam int CMD_W = 10;
  localparam int BYTE_W = 8;
  localparam int SEL_RW_BIT = 0;
  localparam int SEL_SPACE_BIT = 1;
  typedef enum logic [1:0] {
    K_SEL = 2'h0,
    K_WADDR = 2'h1,
    K_NEXT = 2'h2,
    K_STOP = 2'h3
  } cmd_kind_e;

  // Word address byte count
  localparam logic [1:0] WCNT_HI = 2'h0;
  localparam logic [1:0] WCNT_LO = 2'h1;
  localparam logic [1:0] WCNT_FULL = 2'h2;
  localparam logic [1:0] WCNT_DATA = 2'h3;

  // ----------------------------------------
  // Link states
  // ----------------------------------------
  typedef enum logic [2:0] {
    L_IDLE = 3'h0,
    L_ADDR = 3'h1,
    L_ACK = 3'h3,
    L_RXB = 3'h2,
    L_TXB = 3'h6,
    L_MACK = 3'h7
  } link_state_e;

endpackage

/* include/stream_if.sv */
`timescale 1ns/1ps
interface stream_if #(parameter int W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

/* logic/pair_fifo.sv */
`timescale 1ns/1ps
module pair_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  // Filling side
  input wire logic wr_clk,
  input wire logic wr_rst,
  stream_if.snk wr,
  // Draining side
  input wire logic rd_clk,
  input wire logic rd_rst,
  stream_if.src rd
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] PTR_ONE = PW'(1);
  localparam logic [PW-1:0] PTR_DEPTH = PW'(DEPTH);

  function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  function automatic logic [PW-1:0] to_bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = '0;
    for (int i = PW - 1; i >= 0; i--) begin
      b[i] = g[i] ^ ((i == PW - 1) ? 1'b0 : b[i+1]);
    end
    to_bin = b;
  endfunction

  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wbin_q, wgray_q, rs1_q, rs2_q;
  logic [PW-1:0] rbin_q, rgray_q, ws1_q, ws2_q;

  // ----------------------------------------
  // Filling side
  // ----------------------------------------
  wire logic full = (wbin_q - to_bin(rs2_q)) == PTR_DEPTH;
  wire logic push = wr.valid & ~full;
  assign wr.ready = ~full;

  always_ff @(posedge wr_clk) begin
    if (wr_rst) begin
      wbin_q <= '0;
      wgray_q <= '0;
      rs1_q <= '0;
      rs2_q <= '0;
    end else begin
      rs1_q <= rgray_q;
      rs2_q <= rs1_q;
      if (push) begin
        wbin_q <= wbin_q + PTR_ONE;
        wgray_q <= to_gray(wbin_q + PTR_ONE);
      end
    end
  end

  always_ff @(posedge wr_clk) begin
    if (push) begin
      mem_q[wbin_q[AW-1:0]] <= wr.data;
    end
  end

  // ----------------------------------------
  // Draining side
  // ----------------------------------------
  wire logic empty = rgray_q == ws2_q;
  wire logic pop = rd.ready & ~empty;
  assign rd.valid = ~empty;
  assign rd.data = mem_q[rbin_q[AW-1:0]];

  always_ff @(posedge rd_clk) begin
    if (rd_rst) begin
      rbin_q <= '0;
      rgray_q <= '0;
      ws1_q <= '0;
      ws2_q <= '0;
    end else begin
      ws1_q <= wgray_q;
      ws2_q <= ws1_q;
      if (pop) begin
        rbin_q <= rbin_q + PTR_ONE;
        rgray_q <= to_gray(rbin_q + PTR_ONE);
      end
    end
  end
endmodule

/* logic/serial_read_address_logic.sv */
`timescale 1ns/1ps
module serial_read_address_logic #(
  parameter int ADDR_W = rd_seq_pkg::ADDR_W,
  parameter int BUF_DEPTH = 2
) (
  // System clock and reset
  input wire logic clk,
  input wire logic srst,
  // Serial link, open drain
  input wire logic link_clk,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Memory read ports
  output logic [ADDR_W-1:0] rd_addr,
  output logic rd_en,
  output logic rd_space,
  input wire logic [7:0] arr_rdata,
  input wire logic [7:0] ctl_rdata
);
  localparam int CW = rd_seq_pkg::CMD_W;
  localparam int BW = rd_seq_pkg::BYTE_W;
  localparam logic [ADDR_W-1:0] A_RST = ADDR_W'(rd_seq_pkg::ADDR_RST);
  localparam logic [ADDR_W-1:0] A_LAST = ADDR_W'(rd_seq_pkg::ADDR_LAST);
  localparam logic [ADDR_W-1:0] A_ONE = ADDR_W'(1);
  localparam logic [3:0] CNT_ONE = 4'h1;

  stream_if #(.W(CW)) cmd_wr ();
  stream_if #(.W(CW)) cmd_rd ();
  stream_if #(.W(BW)) dat_wr ();
  stream_if #(.W(BW)) dat_rd ();

  // ----------------------------------------
  // Link domain: reset and pin synchronisers
  // ----------------------------------------
  logic [1:0] rst_s_q;
  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic scl_p_q;
  logic sda_p_q;
  wire logic link_rst = rst_s_q[1];

  always_ff @(posedge link_clk) begin
    rst_s_q <= {rst_s_q[0], srst};
    scl_s_q <= {scl_s_q[0], scl_i};
    sda_s_q <= {sda_s_q[0], sda_i};
    scl_p_q <= scl_s_q[1];
    sda_p_q <= sda_s_q[1];
  end

  wire logic scl_now = scl_s_q[1];
  wire logic sda_now = sda_s_q[1];
  wire logic scl_rise = scl_now & ~scl_p_q;
  wire logic scl_fall = ~scl_now & scl_p_q;
  wire logic scl_high = scl_now & scl_p_q;
  wire logic start_det = scl_high & sda_p_q & ~sda_now;
  wire logic stop_det = scl_high & ~sda_p_q & sda_now;

  // ----------------------------------------
  // Link domain: byte engine
  // ----------------------------------------
  rd_seq_pkg::link_state_e state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] rx_q, rx_d;
  logic [7:0] tx_q, tx_d;
  logic rw_q, rw_d;
  logic have_q, have_d;
  logic drv_q, drv_d;
  logic cvld_q, cvld_d;
  logic [CW-1:0] cmd_q, cmd_d;

  wire logic id_arr = rx_q[7:4] == rd_seq_pkg::ID_ARRAY;
  wire logic id_ctl = rx_q[7:4] == rd_seq_pkg::ID_CTRL;
  wire logic sel_ok = rx_q[3:1] == rd_seq_pkg::DEV_SEL;
  wire logic addr_match = (id_arr | id_ctl) & sel_ok;
  wire logic byte_done = cnt_q == rd_seq_pkg::BIT_LAST;
  wire logic in_tx = state_q == rd_seq_pkg::L_TXB;
  wire logic tx_load = in_tx & ~have_q & dat_rd.valid;
  wire logic in_rx = state_q == rd_seq_pkg::L_RXB;
  wire logic in_ack = state_q == rd_seq_pkg::L_ACK;
  wire logic in_mack = state_q == rd_seq_pkg::L_MACK;
  wire logic [CW-1:0] sel_cmd = {rd_seq_pkg::K_SEL, 6'h00, id_ctl, rx_q[0]};
  wire logic [CW-1:0] wad_cmd = {rd_seq_pkg::K_WADDR, rx_q};
  wire logic [CW-1:0] nxt_cmd = {rd_seq_pkg::K_NEXT, 8'h00};
  wire logic [CW-1:0] stp_cmd = {rd_seq_pkg::K_STOP, 8'h00};

  // A stale byte is dropped outside a read; a byte fetched during an
  // acknowledge slot waits for the send state; the clock is held low
  // while a read waits for its byte
  assign dat_rd.ready = tx_load | ~(in_tx | in_ack | in_mack);
  assign scl_oe = in_tx & ~have_q;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign sda_oe = drv_q;
  assign cmd_wr.valid = cvld_q;
  assign cmd_wr.data = cmd_q;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    rx_d = rx_q;
    tx_d = tx_q;
    rw_d = rw_q;
    have_d = have_q;
    drv_d = drv_q;
    cvld_d = cvld_q & ~cmd_wr.ready;
    cmd_d = cmd_q;
    if (start_det) begin
      state_d = rd_seq_pkg::L_ADDR;
      cnt_d = '0;
      drv_d = 1'b0;
      have_d = 1'b0;
    end else if (stop_det) begin
      state_d = rd_seq_pkg::L_IDLE;
      drv_d = 1'b0;
      have_d = 1'b0;
      cvld_d = 1'b1;
      cmd_d = stp_cmd;
    end else begin
      unique case (state_q)
        rd_seq_pkg::L_IDLE: begin
          state_d = rd_seq_pkg::L_IDLE;
        end
        rd_seq_pkg::L_ADDR, rd_seq_pkg::L_RXB: begin
          if (scl_rise && !byte_done) begin
            rx_d = {rx_q[6:0], sda_now};
            cnt_d = cnt_q + CNT_ONE;
          end else if (scl_fall && byte_done) begin
            cnt_d = '0;
            if (in_rx || addr_match) begin
              state_d = rd_seq_pkg::L_ACK;
              drv_d = 1'b1;
              cvld_d = 1'b1;
              cmd_d = in_rx ? wad_cmd : sel_cmd;
              rw_d = in_rx ? rw_q : rx_q[0];
            end else begin
              state_d = rd_seq_pkg::L_IDLE;
            end
          end
        end
        rd_seq_pkg::L_ACK: begin
          if (scl_fall) begin
            drv_d = 1'b0;
            state_d = rw_q ? rd_seq_pkg::L_TXB : rd_seq_pkg::L_RXB;
          end
        end
        rd_seq_pkg::L_TXB: begin
          if (tx_load) begin
            tx_d = dat_rd.data;
            have_d = 1'b1;
            drv_d = ~dat_rd.data[7];
          end else if (scl_rise && have_q) begin
            cnt_d = cnt_q + CNT_ONE;
          end else if (scl_fall && have_q && byte_done) begin
            state_d = rd_seq_pkg::L_MACK;
            drv_d = 1'b0;
            cnt_d = '0;
          end else if (scl_fall && have_q) begin
            tx_d = {tx_q[6:0], 1'b0};
            drv_d = ~tx_q[6];
          end
        end
        rd_seq_pkg::L_MACK: begin
          if (scl_rise) begin
            rx_d[0] = sda_now;
            if (!sda_now) begin
              cvld_d = 1'b1;
              cmd_d = nxt_cmd;
            end
          end else if (scl_fall) begin
            have_d = 1'b0;
            state_d = rx_q[0] ? rd_seq_pkg::L_IDLE : rd_seq_pkg::L_TXB;
          end
        end
        default: begin
          state_d = rd_seq_pkg::L_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state_q <= rd_seq_pkg::L_IDLE;
      cnt_q <= '0;
      rx_q <= '0;
      tx_q <= '0;
      rw_q <= 1'b0;
      have_q <= 1'b0;
      drv_q <= 1'b0;
      cvld_q <= 1'b0;
      cmd_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      rw_q <= rw_d;
      have_q <= have_d;
      drv_q <= drv_d;
      cvld_q <= cvld_d;
      cmd_q <= cmd_d;
    end
  end

  // ----------------------------------------
  // Domain crossings
  // ----------------------------------------
  pair_fifo #(.W(CW), .DEPTH(BUF_DEPTH)) cmd_fifo (
    .wr_clk(link_clk),
    .wr_rst(link_rst),
    .wr(cmd_wr),
    .rd_clk(clk),
    .rd_rst(srst),
    .rd(cmd_rd)
  );

  pair_fifo #(.W(BW), .DEPTH(BUF_DEPTH)) dat_fifo (
    .wr_clk(clk),
    .wr_rst(srst),
    .wr(dat_wr),
    .rd_clk(link_clk),
    .rd_rst(link_rst),
    .rd(dat_rd)
  );

  // ----------------------------------------
  // System domain: address counter and fetch
  // ----------------------------------------
  logic [ADDR_W-1:0] addr_q;
  logic [15:0] pend_q;
  logic [1:0] wcnt_q;
  logic space_q;
  logic rd_en_q;
  logic rdv_q;
  logic hold_q;
  logic [7:0] hold_data_q;

  wire logic busy = rd_en_q | rdv_q | hold_q;
  wire logic take = cmd_rd.valid & ~busy;
  wire logic [1:0] kind = cmd_rd.data[CW-1:BW];
  wire logic [7:0] arg = cmd_rd.data[BW-1:0];
  wire logic is_sel = take & (kind == rd_seq_pkg::K_SEL);
  wire logic is_wad = take & (kind == rd_seq_pkg::K_WADDR);
  wire logic is_stop = take & (kind == rd_seq_pkg::K_STOP);
  wire logic is_next = take & (kind == rd_seq_pkg::K_NEXT);
  wire logic sel_rd = is_sel & arg[rd_seq_pkg::SEL_RW_BIT];
  wire logic wad_full = wcnt_q == rd_seq_pkg::WCNT_FULL;
  wire logic load_now = (sel_rd | is_stop) & wad_full;
  wire logic fire = sel_rd | is_next;
  wire logic at_last = addr_q == A_LAST;
  wire logic [ADDR_W-1:0] addr_inc = at_last ? A_RST : addr_q + A_ONE;
  wire logic [7:0] rdata = space_q ? ctl_rdata : arr_rdata;

  assign cmd_rd.ready = ~busy;
  assign dat_wr.valid = hold_q;
  assign dat_wr.data = hold_data_q;
  assign rd_addr = addr_q;
  assign rd_en = rd_en_q;
  assign rd_space = space_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      addr_q <= A_RST;
      rd_en_q <= 1'b0;
      rdv_q <= 1'b0;
      space_q <= 1'b0;
    end else begin
      rd_en_q <= fire;
      rdv_q <= rd_en_q;
      if (is_sel) begin
        space_q <= arg[rd_seq_pkg::SEL_SPACE_BIT];
      end
      if (load_now) begin
        addr_q <= ADDR_W'(pend_q);
      end else if (rd_en_q) begin
        addr_q <= addr_inc;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wcnt_q <= rd_seq_pkg::WCNT_HI;
      pend_q <= '0;
    end else if (is_sel || is_stop) begin
      wcnt_q <= rd_seq_pkg::WCNT_HI;
    end else if (is_wad && wcnt_q == rd_seq_pkg::WCNT_HI) begin
      pend_q[15:8] <= arg;
      wcnt_q <= rd_seq_pkg::WCNT_LO;
    end else if (is_wad && wcnt_q == rd_seq_pkg::WCNT_LO) begin
      pend_q[7:0] <= arg;
      wcnt_q <= rd_seq_pkg::WCNT_FULL;
    end else if (is_wad) begin
      wcnt_q <= rd_seq_pkg::WCNT_DATA;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hold_q <= 1'b0;
      hold_data_q <= '0;
    end else if (rdv_q) begin
      hold_q <= 1'b1;
      hold_data_q <= rdata;
    end else if (dat_wr.ready) begin
      hold_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_next_taken;
    is_next;
  endsequence

  sequence s_fetch_done;
    ##1 rd_en ##2 hold_q;
  endsequence

  cnt_step_a: assert property (@(posedge clk) disable iff (srst)
    rd_en && !at_last |=> rd_addr == $past(rd_addr) + A_ONE)
    else $error("counter did not advance by one");
  cnt_wrap_a: assert property (@(posedge clk) disable iff (srst)
    rd_en && at_last |=> rd_addr == A_RST)
    else $error("counter did not wrap");
  reset_addr_a: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) |-> rd_addr == A_RST && !rd_en)
    else $error("counter not zero after reset");
  set_addr_a: assert property (@(posedge clk) disable iff (srst)
    is_stop && wad_full |=> rd_addr == ADDR_W'($past(pend_q)) ##1 !rd_en)
    else $error("stop did not load address");
  next_fetch_a: assert property (@(posedge clk) disable iff (srst)
    s_next_taken |-> s_fetch_done)
    else $error("acknowledge did not fetch a byte");
  rand_load_a: assert property (@(posedge clk) disable iff (srst)
    sel_rd && wad_full |=> rd_en && rd_addr == ADDR_W'($past(pend_q)))
    else $error("random read used wrong address");
  space_pick_a: assert property (@(posedge clk) disable iff (srst)
    is_sel |=> rd_space == $past(arg[rd_seq_pkg::SEL_SPACE_BIT]))
    else $error("space not taken from address byte");
  no_match_a: assert property (
    @(posedge link_clk) disable iff (link_rst)
    state_q == rd_seq_pkg::L_ADDR && scl_fall && byte_done && !addr_match
    && !start_det && !stop_det |=> state_q == rd_seq_pkg::L_IDLE && !sda_oe)
    else $error("foreign address answered");
  ack_drive_a: assert property (
    @(posedge link_clk) disable iff (link_rst)
    state_q == rd_seq_pkg::L_ACK |-> sda_oe)
    else $error("acknowledge not driven");
  standby_a: assert property (
    @(posedge link_clk) disable iff (link_rst)
    state_q == rd_seq_pkg::L_IDLE && !start_det
    |=> state_q == rd_seq_pkg::L_IDLE && !sda_oe && !scl_oe)
    else $error("bus activity taken in standby");
endmodule

/* tb/link_master.sv */
`timescale 1ns/1ps
module link_master (
  // Timebase and wire levels
  input wire logic link_clk,
  input wire logic scl,
  input wire logic sda,
  // Open-drain pulls, high pulls the wire low
  output logic scl_low,
  output logic sda_low
);
  int hang_count;

  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    hang_count = 0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge link_clk);
  endtask

  // Release clock and wait out any stretching, bounded
  task automatic scl_up();
    int i;
    scl_low = 1'b0;
    i = 0;
    do begin
      @(negedge link_clk);
      i++;
    end while (scl !== 1'b1 && i < 600);
    if (scl !== 1'b1) hang_count++;
  endtask

  task automatic put_bit(input logic b);
    sda_low = ~b;
    tick(3);
    scl_up();
    tick(5);
    scl_low = 1'b1;
    tick(4);
  endtask

  task automatic get_bit(output logic b);
    sda_low = 1'b0;
    tick(3);
    scl_up();
    tick(2);
    b = sda;
    tick(3);
    scl_low = 1'b1;
    tick(4);
  endtask

  task automatic start();
    sda_low = 1'b0;
    tick(3);
    scl_up();
    tick(4);
    sda_low = 1'b1;
    tick(5);
    scl_low = 1'b1;
    tick(4);
  endtask

  task automatic stop();
    sda_low = 1'b1;
    tick(3);
    scl_up();
    tick(5);
    sda_low = 1'b0;
    tick(5);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i]);
    end
    get_bit(ack);
  endtask

  // Last byte: data line held high through the ninth clock
  task automatic recv_byte(input logic more, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      get_bit(b[i]);
    end
    put_bit(~more);
  endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  // ----------------------------------------
  // Clocks, wires and bench state
  // ----------------------------------------
  logic clk, link_clk, srst, rd_en, rd_space;
  logic scl_o, scl_oe, sda_o, sda_oe, m_scl_low, m_sda_low;
  logic [15:0] rd_addr;
  logic [7:0] arr_rdata, ctl_rdata;
  logic [7:0] arr_mem [256];
  logic [7:0] ctl_mem [256];
  logic [7:0] exp_q [$];
  wire logic scl_w = ~(m_scl_low | scl_oe);
  wire logic sda_w = ~(m_sda_low | sda_oe);
  int fail_count, checks_done, hold_n, exp_addr;

  serial_read_address_logic #(.ADDR_W(16), .BUF_DEPTH(2))
    u_serial_read_address_logic (
    .clk(clk), .srst(srst), .link_clk(link_clk),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .rd_addr(rd_addr), .rd_en(rd_en), .rd_space(rd_space),
    .arr_rdata(arr_rdata), .ctl_rdata(ctl_rdata)
  );

  link_master u_link_master (
    .link_clk(link_clk), .scl(scl_w), .sda(sda_w),
    .scl_low(m_scl_low), .sda_low(m_sda_low)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    link_clk = 1'b0;
    #13;
    forever #80 link_clk = ~link_clk;
  end

  // ----------------------------------------
  // Memory: data held two cycles after a read, scrambled otherwise
  // ----------------------------------------
  always @(negedge clk) begin
    if (rd_en === 1'b1) begin
      arr_rdata <= arr_mem[rd_addr[7:0]] ^ rd_addr[15:8];
      ctl_rdata <= ctl_mem[rd_addr[7:0]] ^ rd_addr[15:8];
      hold_n <= 2;
    end else if (hold_n > 0) begin
      hold_n <= hold_n - 1;
    end else begin
      arr_rdata <= ~arr_rdata;
      ctl_rdata <= ~ctl_rdata;
    end
  end

  // ----------------------------------------
  // Model and helpers
  // ----------------------------------------
  function automatic logic [7:0] exp_byte(input bit sp, input int a);
    if (sp) return ctl_mem[a[7:0]] ^ a[15:8];
    return arr_mem[a[7:0]] ^ a[15:8];
  endfunction

  function automatic logic [7:0] sel(input bit sp, input bit rw);
    return {sp ? rd_seq_pkg::ID_CTRL : rd_seq_pkg::ID_ARRAY,
            rd_seq_pkg::DEV_SEL, rw};
  endfunction

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] seen);
    checks_done++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic rd_seq(input bit sp, input int n);
    logic ack;
    logic [7:0] b;
    u_link_master.start();
    u_link_master.send_byte(sel(sp, 1'b1), ack);
    check("read ack", 16'h0, {15'h0, ack});
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(exp_byte(sp, exp_addr));
      exp_addr = (exp_addr + 1) % 65536;
      u_link_master.recv_byte(i < n - 1, b);
      check("data", {8'h0, exp_q.pop_front()}, {8'h0, b});
    end
    u_link_master.stop();
    repeat (12) @(negedge clk);
    check("counter", exp_addr[15:0], rd_addr);
    check("space", {15'h0, sp}, {15'h0, rd_space});
  endtask

  // Dummy write of a word address, no stop
  task automatic set_addr(input bit sp, input logic [15:0] a);
    logic ack;
    u_link_master.start();
    u_link_master.send_byte(sel(sp, 1'b0), ack);
    check("write ack", 16'h0, {15'h0, ack});
    u_link_master.send_byte(a[15:8], ack);
    check("high ack", 16'h0, {15'h0, ack});
    u_link_master.send_byte(a[7:0], ack);
    check("low ack", 16'h0, {15'h0, ack});
    exp_addr = a;
  endtask

  initial begin
    #4_000_000;
    fail_count++;
    finish_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic ack;
    logic [15:0] ra;
    bit sp;
    int n;
    srst = 1'b1;
    fail_count = 0;
    checks_done = 0;
    exp_addr = 0;
    void'($urandom(20961));
    for (int i = 0; i < 256; i++) begin
      arr_mem[i] = 8'($urandom);
      ctl_mem[i] = 8'($urandom);
    end
    repeat (14) @(negedge clk);
    srst = 1'b0;
    repeat (6) @(negedge link_clk);
    check("counter reset", 16'h0, rd_addr);
    rd_seq(1'b0, 1);
    rd_seq(1'b0, 3);
    set_addr(1'b1, 16'h12fe);
    rd_seq(1'b1, 4);
    set_addr(1'b0, 16'hfffe);
    u_link_master.stop();
    repeat (12) @(negedge clk);
    check("loaded", 16'hfffe, rd_addr);
    u_link_master.send_byte(sel(1'b0, 1'b1), ack);
    check("no start ack", 16'h1, {15'h0, ack});
    u_link_master.stop();
    rd_seq(1'b0, 3);
    u_link_master.start();
    u_link_master.send_byte({4'hb, rd_seq_pkg::DEV_SEL, 1'b1}, ack);
    check("bad id ack", 16'h1, {15'h0, ack});
    u_link_master.start();
    u_link_master.send_byte({rd_seq_pkg::ID_ARRAY, 3'h6, 1'b1}, ack);
    check("bad select ack", 16'h1, {15'h0, ack});
    u_link_master.stop();
    repeat (12) @(negedge clk);
    check("counter kept", exp_addr[15:0], rd_addr);
    for (int k = 0; k < 4; k++) begin
      sp = 1'($urandom);
      ra = 16'($urandom);
      n = 1 + int'($urandom % 3);
      set_addr(sp, ra);
      rd_seq(sp, n);
    end
    check("stretch hangs", 16'h0, u_link_master.hang_count[15:0]);
    check("drive level", 16'h0, {14'h0, scl_o, sda_o});
    finish_test();
  end
endmodule
